// file: design/icd_pkg.sv
package icd_pkg;

    // Register map (indices as seen by the serial port)
    localparam logic [12:0] REG_DUTY_CTRL  = 13'h009;
    localparam logic [12:0] REG_DIV_CTRL   = 13'h00B;
    localparam logic [12:0] REG_SYNC_CTRL  = 13'h100;
    localparam logic [12:0] REG_CLK_STATUS = 13'h102;

    // Field positions
    localparam int          DUTY_EN_BIT    = 0;
    localparam int          SYNC_EN_BIT    = 1;
    localparam int          SYNC_ONCE_BIT  = 2;
    localparam int          ST_ACTIVE_BIT  = 0;
    localparam int          ST_LOCKED_BIT  = 1;
    localparam int          ST_ARMED_BIT   = 2;

    // Values after reset
    localparam logic [7:0]  DUTY_RST       = 8'h01;
    localparam logic [7:0]  DIV_RST        = 8'h00;
    localparam logic [7:0]  SYNC_RST       = 8'h00;

    // Timing
    localparam int          CLK_MHZ        = 250;
    localparam int          CLK_PERIOD_PS  = 4000;
    localparam int          MIN_DCS_MHZ    = 20;
    localparam int          RELOCK_MIN_NS  = 1500;
    localparam int          RELOCK_MAX_NS  = 5000;
    // Longest period still corrected, rounded down
    localparam int          SLOW_CYC       = CLK_MHZ / MIN_DCS_MHZ;
    // Least relock time, rounded up
    localparam int          RELOCK_CYC     = (RELOCK_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Divider limits
    localparam int          DIV_MAX        = 8;

endpackage : icd_pkg

// file: design/icd_stab_if.sv
`timescale 1ns/100ps
// Divided clock events from the divider to the stabiliser and its answer
interface icd_stab_if;
    logic rise;
    logic raw_level;
    logic active;
    logic clk_level;
    logic locked;

    modport core (output rise, output raw_level, output active, input clk_level, input locked);
    modport stab (input rise, input raw_level, input active, output clk_level, output locked);
endinterface : icd_stab_if

// file: design/icd_duty_stab.sv
`timescale 1ns/100ps
module icd_duty_stab #(
    parameter int PER_W = 8,
    parameter int LOCK_W = 16
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // Divider side
    icd_stab_if.stab  bus
);

    localparam logic [PER_W-1:0]  PER_SAT  = {PER_W{1'b1}};
    localparam logic [PER_W-1:0]  SLOW_LIM = PER_W'(icd_pkg::SLOW_CYC);
    localparam logic [LOCK_W-1:0] LOCK_LD  = LOCK_W'(icd_pkg::RELOCK_CYC);

    initial begin
        if (icd_pkg::SLOW_CYC >= 2 ** PER_W) $error("PER_W too small");
        if (icd_pkg::RELOCK_CYC >= 2 ** LOCK_W) $error("LOCK_W too small");
    end

    logic [PER_W-1:0]  cnt_q,  cnt_d;
    logic [PER_W-1:0]  per_q,  per_d;
    logic [LOCK_W-1:0] lock_q, lock_d;
    logic              out_q,  out_d;
    logic [PER_W-1:0]  new_per;
    logic              fast;
    logic              jump;

    // Period measurement, relock timer and regenerated output
    always_comb begin
        new_per = (cnt_q == PER_SAT) ? PER_SAT : cnt_q + 1'b1;
        fast    = (per_q != '0) && (per_q <= SLOW_LIM);
        jump    = (new_per > per_q + 1'b1) || (per_q > new_per + 1'b1);
        cnt_d   = bus.rise ? '0 : new_per;
        per_d   = bus.rise ? new_per : per_q;
        lock_d  = lock_q;
        if (bus.rise) begin
            if (jump || (new_per > SLOW_LIM)) begin
                lock_d = LOCK_LD;                          // Frequency moved, relock
            end else if (lock_q != '0) begin
                lock_d = lock_q - 1'b1;
            end
        end else if (lock_q != '0 && fast) begin
            lock_d = lock_q - 1'b1;
        end
        if (!bus.active || !fast) begin
            out_d = bus.raw_level;                         // Uncorrected below the loop's range
        end else if (bus.rise) begin
            out_d = 1'b1;                                  // Rising edge stays the reference
        end else if (new_per >= (per_q >> 1)) begin
            out_d = 1'b0;                                  // Falling edge at half period
        end else begin
            out_d = out_q;
        end
    end

    // State registers
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_q  <= '0;
            per_q  <= '0;
            lock_q <= LOCK_LD;
            out_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            per_q  <= per_d;
            lock_q <= lock_d;
            out_q  <= out_d;
        end
    end

    assign bus.clk_level = out_q;
    assign bus.locked    = bus.active && fast && (lock_q == '0);

endmodule : icd_duty_stab

// file: design/icd_clock_div.sv
`timescale 1ns/100ps
module icd_clock_div #(
    parameter int MAX_RATIO = icd_pkg::DIV_MAX
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Pins
    input  wire logic        i_sample_clk,
    input  wire logic        i_sync,
    // Register access from the serial port
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [12:0] i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_reg_rvalid,
    // Conversion clock
    output logic             o_conv_clk,
    output logic             o_sample_strobe,
    output logic             o_stab_active,
    output logic             o_stab_locked
);

    // Block notes
    // The sample clock and the sync pin are both asynchronous to i_clk and
    // pass two flip-flops before any edge detection reads them. The input
    // clock must therefore stay at least two system cycles in each half,
    // otherwise edges are lost and the divide ratio appears to drift.
    //
    // Register index map, all registers eight bits wide:
    //   duty control   bit 0 enables the stabiliser
    //   divide control ratio code, divide by code plus one
    //   sync control   bit 1 enables sync, bit 2 first pulse only
    //   clock status   read only: active, locked, armed
    // Unmapped indices ignore writes and read back zero.
    //
    // Ratio codes beyond the served maximum are clamped, so software that
    // writes a wild value still gets the slowest divide rather than a wrap.
    //
    // The one-shot sync mode is armed by any write to sync control and is
    // consumed by the first accepted pulse. A write in the same cycle as an
    // accepted pulse leaves the block armed, so a fresh write is never lost.
    //
    // An accepted sync pulse takes priority over an input rise in the same
    // cycle: the counter returns to its start and the next input rise is
    // the first divided rise. Several devices fed the same pulse thus agree.
    //
    // The stabiliser measures the divided period in system cycles. Below its
    // lower rate limit it passes the raw divided clock untouched, and after a
    // frequency step it reports unlocked until the relock time has run.
    // Software must not rely on the regenerated edge until locked reads one.
    //
    // Read data come from a register and stand until the next read; the
    // valid pulse lasts one cycle.

    initial begin
        if (MAX_RATIO < 1 || MAX_RATIO > icd_pkg::DIV_MAX) $error("MAX_RATIO out of range");
    end

    // Clamp a written ratio code to what the divider serves
    function automatic logic [2:0] clamp_ratio(input logic [7:0] code);
        logic [7:0] lim;
        lim = 8'(MAX_RATIO - 1);
        clamp_ratio = (code > lim) ? lim[2:0] : code[2:0];
    endfunction : clamp_ratio

    icd_stab_if stab_bus ();

    logic [2:0] clk_sy_q;
    logic [2:0] sync_sy_q;
    logic       clk_rise;
    logic       clk_fall;
    logic       sync_rise;

    // Pin synchronisers, first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            clk_sy_q  <= 3'h0;
            sync_sy_q <= 3'h0;
        end else begin
            clk_sy_q  <= {clk_sy_q[1:0], i_sample_clk};
            sync_sy_q <= {sync_sy_q[1:0], i_sync};
        end
    end

    assign clk_rise  = clk_sy_q[1] & ~clk_sy_q[2];
    assign clk_fall  = ~clk_sy_q[1] & clk_sy_q[2];
    assign sync_rise = sync_sy_q[1] & ~sync_sy_q[2];

    logic [7:0] duty_q,  duty_d;
    logic [7:0] div_q,   div_d;
    logic [7:0] sctl_q,  sctl_d;
    logic       armed_q, armed_d;
    logic [7:0] rdata_q, rdata_d;
    logic       rval_q,  rval_d;
    logic       sync_ok;
    logic       wr_sync;

    // Sync pulse accepted per the selected mode
    assign wr_sync = i_reg_wr && (i_reg_addr == icd_pkg::REG_SYNC_CTRL);
    assign sync_ok = sync_rise && sctl_q[icd_pkg::SYNC_EN_BIT]
                     && (!sctl_q[icd_pkg::SYNC_ONCE_BIT] || armed_q);

    // Register file next values
    always_comb begin
        duty_d  = duty_q;
        div_d   = div_q;
        sctl_d  = sctl_q;
        armed_d = armed_q;
        rdata_d = rdata_q;
        rval_d  = i_reg_rd;
        if (sync_ok && sctl_q[icd_pkg::SYNC_ONCE_BIT]) begin
            armed_d = 1'b0;                                // One-shot consumed
        end
        if (wr_sync) begin
            armed_d = 1'b1;                                // Write re-arms, set wins
        end
        if (i_reg_wr) begin
            if (i_reg_addr == icd_pkg::REG_DUTY_CTRL) begin
                duty_d = {7'h00, i_reg_wdata[icd_pkg::DUTY_EN_BIT]};
            end else if (i_reg_addr == icd_pkg::REG_DIV_CTRL) begin
                div_d = {5'h00, clamp_ratio(i_reg_wdata)};
            end else if (i_reg_addr == icd_pkg::REG_SYNC_CTRL) begin
                sctl_d = i_reg_wdata;
            end
        end
        if (i_reg_rd) begin
            if (i_reg_addr == icd_pkg::REG_DUTY_CTRL) begin
                rdata_d = duty_q;
            end else if (i_reg_addr == icd_pkg::REG_DIV_CTRL) begin
                rdata_d = div_q;
            end else if (i_reg_addr == icd_pkg::REG_SYNC_CTRL) begin
                rdata_d = sctl_q;
            end else if (i_reg_addr == icd_pkg::REG_CLK_STATUS) begin
                rdata_d = {5'h00, armed_q, stab_bus.locked, stab_bus.active};
            end else begin
                rdata_d = 8'h00;                           // Unmapped reads zero
            end
        end
    end

    // Register file
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            duty_q  <= icd_pkg::DUTY_RST;
            div_q   <= icd_pkg::DIV_RST;
            sctl_q  <= icd_pkg::SYNC_RST;
            armed_q <= 1'b0;
            rdata_q <= 8'h00;
            rval_q  <= 1'b0;
        end else begin
            duty_q  <= duty_d;
            div_q   <= div_d;
            sctl_q  <= sctl_d;
            armed_q <= armed_d;
            rdata_q <= rdata_d;
            rval_q  <= rval_d;
        end
    end

    logic [2:0] cnt_q, cnt_d;
    logic       raw_q, raw_d;
    logic       stb_q, stb_d;
    logic       emit;

    // Divider: an output rise on every ratio-th input rise
    always_comb begin
        emit  = clk_rise && (cnt_q == 3'h0) && !sync_ok;
        cnt_d = cnt_q;
        raw_d = raw_q;
        if (sync_ok) begin
            cnt_d = 3'h0;                                  // Back to initial count
            raw_d = 1'b0;
        end else if (clk_rise) begin
            cnt_d = (cnt_q >= div_q[2:0]) ? 3'h0 : cnt_q + 3'h1;
            if (emit) begin
                raw_d = 1'b1;
            end
        end else if (clk_fall) begin
            raw_d = 1'b0;                                  // Uncorrected fall follows the input
        end
        stb_d = emit;                                      // Sample on conversion clock rise
    end

    // Divider state
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_q <= 3'h0;
            raw_q <= 1'b0;
            stb_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            raw_q <= raw_d;
            stb_q <= stb_d;
        end
    end

    // Stabiliser forced on for any ratio but one
    assign stab_bus.active    = duty_q[icd_pkg::DUTY_EN_BIT] || (div_q[2:0] != 3'h0);
    assign stab_bus.rise      = emit;
    assign stab_bus.raw_level = raw_d;

    icd_duty_stab #(
        .PER_W  (8),
        .LOCK_W (16)
    ) u_stab (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .bus    (stab_bus)
    );

    // Outputs
    assign o_reg_rdata     = rdata_q;
    assign o_reg_rvalid    = rval_q;
    assign o_conv_clk      = stab_bus.clk_level;
    assign o_sample_strobe = stb_q;
    assign o_stab_active   = stab_bus.active;
    assign o_stab_locked   = stab_bus.locked;

endmodule : icd_clock_div

// file: bench/icd_src_model.sv
`timescale 1ns/100ps
// Sample clock source and sync pin driver
module icd_src_model (
    // Clock
    input  wire logic       i_clk,
    // Control from the bench
    input  wire logic [4:0] i_hi,
    input  wire logic [4:0] i_lo,
    input  wire logic       i_go,
    // Pins
    output logic            o_sample_clk,
    output logic            o_sync
);
    logic [4:0] cnt_q = 5'h00;
    logic [1:0] sc_q  = 2'h0;
    initial begin
        o_sample_clk = 1'b0;
        o_sync       = 1'b0;
    end
    // Free running clock, high and low times in system cycles; sync held three cycles
    always @(posedge i_clk) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q + 5'h01 >= (o_sample_clk ? i_hi : i_lo)) begin
            cnt_q        <= 5'h00;
            o_sample_clk <= !o_sample_clk;
        end
        sc_q   <= i_go ? 2'h2 : (sc_q == 2'h0 ? 2'h0 : sc_q - 2'h1);
        o_sync <= i_go || sc_q != 2'h0;
    end
endmodule : icd_src_model

// file: bench/icd_clock_div_asserts.sv
`timescale 1ns/100ps
// Port checks for the divider
module icd_clock_div_asserts (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [12:0] i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        o_reg_rvalid,
    input wire logic        o_conv_clk,
    input wire logic        o_sample_strobe,
    input wire logic        o_stab_active,
    input wire logic        o_stab_locked
);
    logic       duty_q;
    logic       nz_q;
    logic [7:0] sync_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Shadow of the written control fields
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            duty_q <= 1'b1;
            nz_q   <= 1'b0;
            sync_q <= 8'h00;
        end else if (i_reg_wr) begin
            if (i_reg_addr == icd_pkg::REG_DUTY_CTRL) duty_q <= i_reg_wdata[icd_pkg::DUTY_EN_BIT];
            if (i_reg_addr == icd_pkg::REG_DIV_CTRL) nz_q <= |i_reg_wdata;
            if (i_reg_addr == icd_pkg::REG_SYNC_CTRL) sync_q <= i_reg_wdata;
        end
    end
    strobe_rise_a: assert property (o_sample_strobe == $rose(o_conv_clk))
        else $error("strobe apart from clock rise");
    strobe_pulse_a: assert property (o_sample_strobe |=> !o_sample_strobe)
        else $error("strobe longer than one cycle");
    stab_force_a: assert property (o_stab_active == (duty_q || nz_q))
        else $error("stabiliser state wrong");
    lock_active_a: assert property (o_stab_locked |-> o_stab_active)
        else $error("locked while inactive");
    read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    rvalid_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_rd))
        else $error("answer without read");
    sync_back_a: assert property (i_reg_rd && i_reg_addr == icd_pkg::REG_SYNC_CTRL |=> o_reg_rdata == $past(sync_q))
        else $error("sync control readback wrong");
    status_read_a: assert property (i_reg_rd && i_reg_addr == icd_pkg::REG_CLK_STATUS |=>
        o_reg_rdata[0] == $past(o_stab_active) && o_reg_rdata[1] == $past(o_stab_locked))
        else $error("status readback wrong");
    strobe_c: cover property (o_sample_strobe);
    lock_c: cover property ($rose(o_stab_locked));
    status_c: cover property (i_reg_rd && i_reg_addr == icd_pkg::REG_CLK_STATUS);
endmodule : icd_clock_div_asserts
bind icd_clock_div icd_clock_div_asserts u_chk (.i_clk, .i_rstn, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_conv_clk, .o_sample_strobe, .o_stab_active, .o_stab_locked);

// file: bench/icd_clock_div_tb.sv
`timescale 1ns/100ps
module icd_clock_div_tb;
    logic        i_clk = 1'b0, i_rstn = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [12:0] i_reg_addr = 13'h000;
    logic [7:0]  i_reg_wdata = 8'h00, o_reg_rdata;
    logic        o_reg_rvalid, o_conv_clk, o_sample_strobe, o_stab_active, o_stab_locked;
    logic        smp_clk, sync_pin, go = 1'b0;
    logic [4:0]  hi = 5'h02, lo = 5'h02;
    int          fails = 0, num_checks = 0, n;
    logic [7:0]  sync_wr[6] = '{8'h00, 8'h02, 8'hFF, 8'h06, 8'hFF, 8'h06};
    bit          sync_early[6] = '{0, 1, 1, 1, 0, 1};
    // System clock
    initial begin
        forever #2 i_clk = !i_clk;
    end
    icd_clock_div uut (.i_clk, .i_rstn, .i_sample_clk(smp_clk), .i_sync(sync_pin), .i_reg_wr, .i_reg_rd,
        .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_conv_clk, .o_sample_strobe,
        .o_stab_active, .o_stab_locked);
    icd_src_model src (.i_clk, .i_hi(hi), .i_lo(lo), .i_go(go), .o_sample_clk(smp_clk), .o_sync(sync_pin));
    function automatic int exp_gap(int k);
        return ((k > 7 ? 7 : k) + 1) * (hi + lo);
    endfunction : exp_gap
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [12:0] a, input logic [7:0] exp);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        // Answer launched at this edge, look once it has settled
        #1;
        check("rvalid", 16'h0001, 16'(o_reg_rvalid));
        check("rdata", 16'(exp), 16'(o_reg_rdata));
        @(posedge i_clk);
    endtask : rd
    // Bounded wait for the next strobe, c counts cycles
    task automatic wait_strobe(output int c);
        c = 0;
        do begin
            @(posedge i_clk);
            c++;
        end while (o_sample_strobe !== 1'b1 && c < 200);
        if (c >= 200) begin
            fails++;
            test_done();
        end
    endtask : wait_strobe
    initial begin
        void'($urandom(32'hE2137EA2));
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        // Reset values, unmapped space, random readback
        rd(icd_pkg::REG_DUTY_CTRL, icd_pkg::DUTY_RST);
        rd(icd_pkg::REG_DIV_CTRL, icd_pkg::DIV_RST);
        rd(icd_pkg::REG_SYNC_CTRL, icd_pkg::SYNC_RST);
        rd(13'h103 + 13'($urandom % 200), 8'h00);
        n = $urandom;
        wr(icd_pkg::REG_SYNC_CTRL, 8'(n));
        rd(icd_pkg::REG_SYNC_CTRL, 8'(n));
        // Every ratio, random clock shape, out-of-range code clamps
        wr(icd_pkg::REG_DUTY_CTRL, 8'h00);
        wr(icd_pkg::REG_SYNC_CTRL, 8'h00);
        for (int k = 0; k < 9; k++) begin
            hi <= 5'(2 + $urandom % 3);
            lo <= 5'(2 + $urandom % 3);
            wr(icd_pkg::REG_DIV_CTRL, k == 8 ? 8'hF3 : 8'(k));
            check("active", 16'(k != 0), 16'(o_stab_active));
            repeat (4) wait_strobe(n);
            wait_strobe(n);
            check("gap", 16'(exp_gap(k)), 16'(n));
        end
        // Duty on, duty off, then a clock too slow to correct
        wr(icd_pkg::REG_DIV_CTRL, 8'h00);
        for (int k = 0; k < 3; k++) begin
            hi <= 5'h02;
            lo <= k == 2 ? 5'h0E : 5'h08;
            wr(icd_pkg::REG_DUTY_CTRL, 8'(k != 1));
            repeat (3) wait_strobe(n);
            wait_strobe(n);
            for (n = 0; o_conv_clk === 1'b1 && n < 40; n++) @(posedge i_clk);
            check("high", 16'(k == 0 ? (2 + 8) / 2 : 2), 16'(n));
        end
        check("slow lock", 16'h0000, 16'(o_stab_locked));
        lo <= 5'h08;
        repeat (100) @(posedge i_clk);
        check("early lock", 16'h0000, 16'(o_stab_locked));
        repeat (400) @(posedge i_clk);
        rd(icd_pkg::REG_CLK_STATUS, 8'h07);
        // Sync modes: off, every pulse, first after write only
        wr(icd_pkg::REG_DIV_CTRL, 8'h03);
        hi <= 5'h04;
        lo <= 5'h04;
        for (int k = 0; k < 6; k++) begin
            if (sync_wr[k] != 8'hFF) wr(icd_pkg::REG_SYNC_CTRL, sync_wr[k]);
            repeat (2) wait_strobe(n);
            go <= 1'b1;
            @(posedge i_clk);
            go <= 1'b0;
            wait_strobe(n);
            check("sync early", 16'(sync_early[k]), 16'(n <= 16));
        end
        test_done();
    end
endmodule : icd_clock_div_tb
